// *** testbench.sv ***
// self-checking bench for the translation lookup block
// assumes the walker model answers every walk a few cycles later
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tlbm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic req_valid = 1'b0;
  tlbm_req_s req = '0;
  logic req_ready, resp_valid, walk_req_valid;
  tlbm_resp_s resp;
  tlbm_walk_s walk_req;
  logic walk_resp_valid, walk_resp_fault;
  tlbm_entry_s walk_resp;
  logic berr_valid = 1'b0;
  tlbm_berr_s berr = '0;
  logic abort_valid, bus_error_irq_n;
  tlbm_abort_s abort;
  int failures = 0;
  int comparisons = 0;
  int n;
  logic wk, wl, wd;
  logic [31:0] d;
  logic sd = 1'b1;
  int hit_n = 1;
  localparam logic [31:0] A = 32'h00123000;

  always #2 clk = ~clk;

  tlbm_core dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
    .walk_req_valid(walk_req_valid), .walk_req(walk_req),
    .walk_resp_valid(walk_resp_valid), .walk_resp_fault(walk_resp_fault),
    .walk_resp(walk_resp), .berr_valid(berr_valid), .berr(berr),
    .abort_valid(abort_valid), .abort(abort),
    .bus_error_irq_n(bus_error_irq_n));

  tlbm_walker_model #(.DELAY(3)) walker (.clk(clk), .rst_n(rst_n),
    .walk_req_valid(walk_req_valid), .walk_req(walk_req),
    .walk_resp_valid(walk_resp_valid), .walk_resp_fault(walk_resp_fault),
    .walk_resp(walk_resp));

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // one lookup; checks walk use, fault and address
  task automatic tx(input logic [31:0] va, input logic ns, hy, w,
                    input tlbm_fault_e f);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{va: va, nonsecure: ns, hyp: hy, privileged: 1'b1,
      write: 1'b0, side: sd};
    @(posedge clk);
    req_valid <= 1'b0;
    n = 1;
    wk = 1'b0;
    #1;
    while (n < 200 && resp_valid !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (walk_req_valid === 1'b1 && !wk) begin
        wk = 1'b1;
        wl = walk_req.long_format;
        wd = walk_req.to_dcache;
      end
    end
    chk("answer", resp_valid, 1);
    chk("walk", wk, w);
    chk("fault", resp.fault, f);
    if (f == FLT_NONE) chk("pa", resp.pa, va ^ 32'h40000000);
    if (!w && f == FLT_NONE) chk("hit cycles", n, hit_n);
  endtask

  task automatic be(input tlbm_berr_e k, input logic [31:0] a);
    @(posedge clk);
    berr_valid <= 1'b1;
    berr <= '{kind: k, addr: a};
    @(posedge clk);
    berr_valid <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("ready", req_ready, 1);
    chk("irq idle", bus_error_irq_n, 1);
    wr(REG_DOMAIN, 32'h1);
    wr(REG_CTL_NS, 32'h2);
    tx(A, 1, 0, 0, FLT_TRANSLATION);
    chk("fault cycles", n, 7);
    wr(REG_CTL_NS, 32'h60);
    tx(A, 1, 0, 1, FLT_NONE);
    chk("short", wl, 0);
    chk("dcache", wd, 1);
    tx(A, 1, 0, 0, FLT_NONE);
    tx(A + 32'hffc, 1, 0, 0, FLT_NONE);
    tx(A + 32'h1000, 1, 0, 1, FLT_NONE);
    tx(A, 0, 0, 1, FLT_NONE);
    chk("no dcache", wd, 0);
    tx(A, 1, 1, 1, FLT_NONE);
    chk("hyp long", wl, 1);
    wr(REG_CTL_NS, 32'h61);
    tx(A + 32'h2000, 1, 0, 1, FLT_NONE);
    chk("long", wl, 1);
    wr(REG_CONTEXT, 32'h5);
    tx(A, 1, 0, 1, FLT_NONE);
    tx(A, 1, 1, 0, FLT_NONE);
    tx(A, 0, 0, 1, FLT_NONE);
    wr(REG_STAGE2, 32'h7);
    tx(A, 1, 0, 1, FLT_NONE);
    tx(A, 0, 0, 0, FLT_NONE);
    wr(REG_CTL_NS, 32'h60);
    wr(REG_DOMAIN, 32'h0);
    tx(A, 1, 0, 0, FLT_DOMAIN);
    wr(REG_DOMAIN, 32'h1);
    wr(REG_TLBOP, 32'h1);
    tx(A, 1, 0, 1, FLT_NONE);
    sd = 1'b0;
    hit_n = 2;
    tx(A, 1, 0, 0, FLT_NONE);
    sd = 1'b1;
    hit_n = 1;
    tx(A + 32'h01000000, 1, 0, 1, FLT_PERMISSION);
    tx(A + 32'h02000000, 1, 0, 1, FLT_TRANSLATION);
    be(BERR_LOAD, 32'h0000abc4);
    chk("abort", abort_valid, 1);
    chk("sync", abort.sync, 1);
    chk("monitor", abort.to_monitor, 0);
    rd(REG_FAULT_ADDR);
    chk("fault addr", d, 32'h0000abc4);
    wr(REG_SECCFG, 32'h1);
    be(BERR_WRITE_NC, 32'h00005550);
    chk("abort", abort_valid, 1);
    chk("async", abort.sync, 0);
    chk("monitor", abort.to_monitor, 1);
    for (int k = 2; k < 5; k++) begin
      be(tlbm_berr_e'(k), 32'h00000040);
      chk("no abort", abort_valid, 0);
      repeat (3) @(posedge clk);
      #1 chk("irq", bus_error_irq_n, 0);
      rd(REG_STATUS);
      chk("pending", d, 32'h1);
      wr(REG_STATUS, 32'h1);
      #1 chk("irq clr", bus_error_irq_n, 1);
    end
    rd(8'hfc);
    chk("unmapped", d, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// *** tlbm_core.sv ***
// translation lookup: micro arrays, main array, walk hand-off, bus errors
// assumes requesters hold req until req_ready and the walker answers once
// What this block does
// [R1] entry holds page, size, address, attributes
// [R2] entry holds app tag or global mark
// [R3] entry records allocating virtual machine tag
// [R4] entry records hypervisor-mode allocation
// [R5] compare address bits 31 down to N
// [R6] security state must match entry bit
// [R7] hypervisor flag must match request
// [R8] app tag must match unless global
// [R9] virtual machine tag must match
// [R10] hypervisor requests skip both tag compares
// [R11] secure requests skip machine tag compare
// [R12] micro, then main, then table walk
// [R13] walk format from current-state control bit
// [R14] hypervisor walks use long; stage-two walks follow the control bit
// [R15] write-back walks read the data cache
// [R16] disabled walk returns translation fault
// [R17] hit checks permissions and domain
// [R18] external aborts routed to monitor if set
// [R19] write errors may abort asynchronously
// [R20] cacheable write errors raise interrupt only
// [R21] load errors abort synchronously, capture address
// [R22] non-aborting read errors raise interrupt
// [R23] ten-entry single-cycle micro per side
// [R24] 256-entry two-way main; flush micros
// [R25] interrupt low, held until software clear
`timescale 1ns/1ns
`default_nettype none
module tlbm_core
  import tlbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire tlbm_req_s req,
  output logic req_ready,
  output logic resp_valid,
  output tlbm_resp_s resp,
  output logic walk_req_valid,
  output tlbm_walk_s walk_req,
  input wire logic walk_resp_valid,
  input wire logic walk_resp_fault,
  input wire tlbm_entry_s walk_resp,
  input wire logic berr_valid,
  input wire tlbm_berr_s berr,
  output logic abort_valid,
  output tlbm_abort_s abort,
  output logic bus_error_irq_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_MAIN, ST_WALK} tlbm_state_e;

  tlbm_state_e state_reg;
  logic [2:0] probe_reg;
  tlbm_req_s cur_reg;
  logic [TAG_W-1:0] context_tag_reg;
  logic [TAG_W-1:0] stage2_base_reg;
  logic [CTL_W-1:0] ctl_s_reg;
  logic [CTL_W-1:0] ctl_ns_reg;
  logic [31:0] domain_reg;
  logic ext_abort_route_bit;
  logic berr_pend_reg;
  logic [VA_W-1:0] data_fault_addr_reg;
  logic [31:0] rdata_reg;
  logic resp_valid_reg;
  tlbm_resp_s resp_reg;
  logic walk_valid_reg;
  tlbm_walk_s walk_reg;
  logic abort_valid_reg;
  tlbm_abort_s abort_reg;
  logic main_victim_reg;

  // [R1] stored entry layout
  tlbm_entry_s micro_mem [NUM_SIDES][MICRO_N];
  logic [MICRO_N-1:0] micro_vld [NUM_SIDES];
  logic [MICRO_IDX_W-1:0] micro_victim_reg [NUM_SIDES];
  tlbm_entry_s main_mem [MAIN_WAYS][MAIN_SETS];
  logic [MAIN_SETS-1:0] main_vld [MAIN_WAYS];

  function automatic logic [4:0] tlbm_probe_shift(input logic [2:0] p);
    case (p)
      3'h0: return SHIFT_4K;
      3'h1: return SHIFT_64K;
      3'h2: return SHIFT_1M;
      3'h3: return SHIFT_2M;
      3'h4: return SHIFT_16M;
      default: return SHIFT_1G;
    endcase
  endfunction

  function automatic logic tlbm_match(input tlbm_entry_s e,
      input tlbm_req_s r, input logic [TAG_W-1:0] app_tag,
      input logic [TAG_W-1:0] vm_tag);
    logic va_ok;
    logic app_ok;
    logic vm_ok;
    // [R5] page-size masked compare
    va_ok = ((e.va ^ r.va) >> e.page_shift) == '0;
    // [R8] [R10] app tag unless global or hypervisor
    app_ok = r.hyp || e.global_entry || (e.app_space_tag == app_tag);
    // [R9] [R10] [R11] machine tag only for non-secure guests
    vm_ok = r.hyp || !r.nonsecure || (e.virtual_machine_tag == vm_tag);
    // [R6] [R7] security and hypervisor flags
    return va_ok && (e.nonsecure_entry_bit == r.nonsecure) &&
      (e.hyp == r.hyp) && app_ok && vm_ok;
  endfunction

  function automatic tlbm_fault_e tlbm_check(input tlbm_entry_s e,
      input tlbm_req_s r, input logic short_fmt, input logic [31:0] dac);
    logic [1:0] dom;
    dom = dac[{e.domain, 1'b0} +: 2];
    // [R17] domain first, then access permission
    if (short_fmt && dom == DOM_NONE)
      return FLT_DOMAIN;
    if (short_fmt && dom == DOM_MANAGER)
      return FLT_NONE;
    if (!e.ap[AP_EN] || (!r.privileged && !e.ap[AP_USER]) ||
        (r.write && e.ap[AP_RO]))
      return FLT_PERMISSION;
    return FLT_NONE;
  endfunction

  function automatic logic [PA_W-1:0] tlbm_xlate(input tlbm_entry_s e,
      input logic [VA_W-1:0] va);
    logic [PA_W-1:0] mask;
    mask = (32'h1 << e.page_shift) - 32'h1;
    return (e.pa & ~mask) | (va & mask);
  endfunction

  // lookup context: the incoming request while idle, else the held one
  tlbm_req_s lk_req;
  logic [CTL_W-1:0] ctl_cur;
  logic base1;
  logic long_fmt;
  logic walk_dis;
  logic [1:0] walk_ic;
  logic [4:0] probe_shift;
  logic [SET_W-1:0] probe_set;
  logic micro_hit;
  tlbm_entry_s micro_ent;
  logic main_hit;
  tlbm_entry_s main_ent;
  tlbm_entry_s fill_ent;
  logic fill_main;
  logic fill_micro;
  logic tlb_flush;
  logic berr_clear;
  logic berr_irq_ev;

  assign lk_req = (state_reg == ST_IDLE) ? req : cur_reg;
  // [R13] control of the requester's security state
  assign ctl_cur = lk_req.nonsecure ? ctl_ns_reg : ctl_s_reg;
  assign base1 = lk_req.va[VA_BASE_SEL];
  // [R14] hypervisor translation forces long format
  assign long_fmt = ctl_cur[CTL_LFE] || lk_req.hyp;
  assign walk_ic = base1 ? ctl_cur[CTL_IC1 +: 2] : ctl_cur[CTL_IC0 +: 2];
  always_comb begin
    if (long_fmt)
      walk_dis = base1 ? ctl_cur[CTL_WD1L] : ctl_cur[CTL_WD0L];
    else
      walk_dis = base1 ? ctl_cur[CTL_WD1S] : ctl_cur[CTL_WD0S];
  end

  // [R23] single-cycle micro lookup on the side's own array
  always_comb begin
    micro_hit = 1'b0;
    micro_ent = micro_mem[lk_req.side][0];
    for (int i = 0; i < MICRO_N; i++) begin
      if (micro_vld[lk_req.side][i] && tlbm_match(micro_mem[lk_req.side][i],
          lk_req, context_tag_reg, stage2_base_reg)) begin
        micro_hit = 1'b1;
        micro_ent = micro_mem[lk_req.side][i];
      end
    end
  end

  // [R24] one size probed per cycle, set taken from the page number
  assign probe_shift = tlbm_probe_shift(probe_reg);
  assign probe_set = SET_W'(lk_req.va >> probe_shift);
  always_comb begin
    main_hit = 1'b0;
    main_ent = main_mem[0][probe_set];
    for (int w = 0; w < MAIN_WAYS; w++) begin
      if (main_vld[w][probe_set] &&
          main_mem[w][probe_set].page_shift == probe_shift &&
          tlbm_match(main_mem[w][probe_set], lk_req, context_tag_reg,
          stage2_base_reg)) begin
        main_hit = 1'b1;
        main_ent = main_mem[w][probe_set];
      end
    end
  end

  // [R2] [R3] [R4] allocation stamps the requester's context
  always_comb begin
    fill_ent = walk_resp;
    fill_ent.app_space_tag = context_tag_reg;
    fill_ent.virtual_machine_tag = stage2_base_reg;
    fill_ent.nonsecure_entry_bit = cur_reg.nonsecure;
    fill_ent.hyp = cur_reg.hyp;
    if (state_reg == ST_MAIN)
      fill_ent = main_ent;
  end

  assign fill_main = state_reg == ST_WALK && walk_resp_valid &&
    !walk_resp_fault;
  assign fill_micro = fill_main || (state_reg == ST_MAIN && main_hit);
  assign tlb_flush = reg_wr && reg_addr == REG_TLBOP;
  assign req_ready = state_reg == ST_IDLE;

  // [R12] micro, then main sizes, then walk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      probe_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          probe_reg <= '0;
          if (req_valid && !micro_hit)
            state_reg <= ST_MAIN;
        end
        ST_MAIN: begin
          probe_reg <= probe_reg + 3'h1;
          if (main_hit || (probe_reg == PROBE_LAST && walk_dis))
            state_reg <= ST_IDLE;
          else if (probe_reg == PROBE_LAST)
            state_reg <= ST_WALK;
        end
        ST_WALK: begin
          if (walk_resp_valid)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      cur_reg <= '0;
    else if (state_reg == ST_IDLE && req_valid)
      cur_reg <= req;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_valid_reg <= 1'b0;
      resp_reg <= '0;
    end else begin
      resp_valid_reg <= 1'b0;
      resp_reg.side <= lk_req.side;
      if (state_reg == ST_IDLE && req_valid && micro_hit) begin
        resp_valid_reg <= 1'b1;
        resp_reg.pa <= tlbm_xlate(micro_ent, lk_req.va);
        resp_reg.mem_type <= micro_ent.mem_type;
        resp_reg.fault <= tlbm_check(micro_ent, lk_req, !long_fmt,
          domain_reg);
      end else if (fill_micro) begin
        resp_valid_reg <= 1'b1;
        resp_reg.pa <= tlbm_xlate(fill_ent, lk_req.va);
        resp_reg.mem_type <= fill_ent.mem_type;
        resp_reg.fault <= tlbm_check(fill_ent, lk_req, !long_fmt,
          domain_reg);
      end else if ((state_reg == ST_MAIN && probe_reg == PROBE_LAST &&
          walk_dis) || (state_reg == ST_WALK && walk_resp_valid)) begin
        // [R16] disabled or failed walk gives translation fault
        resp_valid_reg <= 1'b1;
        resp_reg.pa <= '0;
        resp_reg.mem_type <= '0;
        resp_reg.fault <= FLT_TRANSLATION;
      end
    end
  end

  // walk request stands until the walker answers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      walk_valid_reg <= 1'b0;
      walk_reg <= '0;
    end else if (state_reg == ST_MAIN && probe_reg == PROBE_LAST &&
        !main_hit && !walk_dis) begin
      walk_valid_reg <= 1'b1;
      walk_reg.va <= lk_req.va;
      walk_reg.base_sel <= base1;
      // [R13] [R14] format and stage-two need
      walk_reg.long_format <= long_fmt;
      walk_reg.stage2 <= lk_req.nonsecure && !lk_req.hyp;
      // [R15] write-back tables are read through the data cache
      walk_reg.to_dcache <= walk_ic == IC_WB || walk_ic == IC_WBWA;
    end else if (walk_resp_valid) begin
      walk_valid_reg <= 1'b0;
    end
  end

  // [R23] [R24] micro refill, flushed by any main maintenance
  for (genvar s = 0; s < NUM_SIDES; s++) begin : g_micro
    always_ff @(posedge clk) begin
      if (!rst_n || tlb_flush) begin
        micro_vld[s] <= '0;
        micro_victim_reg[s] <= '0;
      end else if (fill_micro && cur_reg.side == s) begin
        micro_vld[s][micro_victim_reg[s]] <= 1'b1;
        if (micro_victim_reg[s] == MICRO_LAST)
          micro_victim_reg[s] <= '0;
        else
          micro_victim_reg[s] <= micro_victim_reg[s] + 4'h1;
      end
    end
    always_ff @(posedge clk) begin
      if (fill_micro && cur_reg.side == s)
        micro_mem[s][micro_victim_reg[s]] <= fill_ent;
    end
  end

  // [R24] two ways, round-robin victim
  always_ff @(posedge clk) begin
    if (!rst_n || tlb_flush) begin
      for (int w = 0; w < MAIN_WAYS; w++)
        main_vld[w] <= '0;
      main_victim_reg <= 1'b0;
    end else if (fill_main) begin
      main_vld[main_victim_reg][SET_W'(walk_resp.va >>
        walk_resp.page_shift)] <= 1'b1;
      main_victim_reg <= !main_victim_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (fill_main)
      main_mem[main_victim_reg][SET_W'(walk_resp.va >>
        walk_resp.page_shift)] <= fill_ent;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      context_tag_reg <= '0;
      stage2_base_reg <= '0;
      ctl_s_reg <= CTL_RESET;
      ctl_ns_reg <= CTL_RESET;
      domain_reg <= '0;
      ext_abort_route_bit <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CONTEXT: context_tag_reg <= reg_wdata[TAG_W-1:0];
        REG_STAGE2: stage2_base_reg <= reg_wdata[TAG_W-1:0];
        REG_CTL_S: ctl_s_reg <= reg_wdata[CTL_W-1:0];
        REG_CTL_NS: ctl_ns_reg <= reg_wdata[CTL_W-1:0];
        REG_DOMAIN: domain_reg <= reg_wdata;
        REG_SECCFG: ext_abort_route_bit <= reg_wdata[SEC_ROUTE];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_CONTEXT: rdata_reg <= 32'(context_tag_reg);
          REG_STAGE2: rdata_reg <= 32'(stage2_base_reg);
          REG_CTL_S: rdata_reg <= 32'(ctl_s_reg);
          REG_CTL_NS: rdata_reg <= 32'(ctl_ns_reg);
          REG_DOMAIN: rdata_reg <= domain_reg;
          REG_SECCFG: rdata_reg <= 32'(ext_abort_route_bit);
          REG_STATUS: rdata_reg <= 32'(berr_pend_reg);
          REG_FAULT_ADDR: rdata_reg <= data_fault_addr_reg;
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  // [R20] [R22] errors that never abort go to the interrupt
  assign berr_irq_ev = berr_valid && (berr.kind == BERR_WRITE_C ||
    berr.kind == BERR_IFETCH_DIRTY || berr.kind == BERR_DVM);
  assign berr_clear = reg_wr && reg_addr == REG_STATUS &&
    reg_wdata[STAT_BERR];

  // [R25] sticky until write-one-to-clear; a new error beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n)
      berr_pend_reg <= 1'b0;
    else if (berr_irq_ev)
      berr_pend_reg <= 1'b1;
    else if (berr_clear)
      berr_pend_reg <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      abort_valid_reg <= 1'b0;
      abort_reg <= '0;
      data_fault_addr_reg <= '0;
    end else begin
      abort_valid_reg <= 1'b0;
      if (berr_valid && (berr.kind == BERR_LOAD ||
          berr.kind == BERR_WRITE_NC)) begin
        abort_valid_reg <= 1'b1;
        // [R18] monitor routing follows the security config bit
        abort_reg.to_monitor <= ext_abort_route_bit;
        abort_reg.addr <= berr.addr;
        // [R19] [R21] loads precise, writes imprecise
        abort_reg.sync <= berr.kind == BERR_LOAD;
        if (berr.kind == BERR_LOAD)
          data_fault_addr_reg <= berr.addr;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign resp_valid = resp_valid_reg;
  assign resp = resp_reg;
  assign walk_req_valid = walk_valid_reg;
  assign walk_req = walk_reg;
  assign abort_valid = abort_valid_reg;
  assign abort = abort_reg;
  assign bus_error_irq_n = !berr_pend_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_load_err;
    berr_valid && berr.kind == BERR_LOAD;
  endsequence
  sequence seq_sync_abort;
    abort_valid && abort.sync && data_fault_addr_reg == $past(berr.addr);
  endsequence
  sequence seq_walk_off;
    state_reg == ST_MAIN && probe_reg == PROBE_LAST && !main_hit &&
      walk_dis;
  endsequence

  chk_load_abort_sync: assert property ( // [R21]
    seq_load_err |=> seq_sync_abort)
    else $error("load error did not abort precisely");
  chk_write_c_irq: assert property ( // [R20]
    berr_valid && berr.kind == BERR_WRITE_C |=>
      !abort_valid && !bus_error_irq_n)
    else $error("cacheable write error mishandled");
  chk_write_async: assert property ( // [R19]
    berr_valid && berr.kind == BERR_WRITE_NC |=> abort_valid && !abort.sync)
    else $error("write error not imprecise abort");
  chk_abort_route: assert property ( // [R18]
    abort_valid |-> abort.to_monitor == $past(ext_abort_route_bit))
    else $error("abort routing wrong");
  chk_irq_held: assert property ( // [R25]
    !bus_error_irq_n && !berr_clear |=> !bus_error_irq_n)
    else $error("interrupt dropped without clear");
  chk_walk_disabled: assert property ( // [R16]
    seq_walk_off |=> resp_valid && resp.fault == FLT_TRANSLATION &&
      !walk_req_valid)
    else $error("disabled walk not faulted");
  chk_hyp_long: assert property ( // [R14]
    walk_req_valid && $rose(walk_req_valid) && $past(lk_req.hyp) |->
      walk_req.long_format)
    else $error("hypervisor walk not long format");
  chk_micro_one: assert property ( // [R23]
    req_valid && req_ready && micro_hit |=> resp_valid ##1 !resp_valid)
    else $error("micro hit not answered next cycle");
  chk_flush_micro: assert property ( // [R24]
    tlb_flush |=> micro_vld[0] == '0 && micro_vld[1] == '0 &&
      main_vld[0] == '0 && main_vld[1] == '0)
    else $error("maintenance did not flush");
  chk_miss_chain: assert property ( // [R12]
    req_valid && req_ready && !micro_hit |=> state_reg == ST_MAIN [*1]
      ##[0:6] (resp_valid || state_reg == ST_WALK))
    else $error("miss did not proceed down the chain");

endmodule
`default_nettype wire

// *** tlbm_pkg.sv ***
// constants, field layouts and carriers for the translation lookup block
// assumes a single 250 MHz clock domain and a plain register port
package tlbm_pkg;

  localparam int VA_W = 32;
  localparam int PA_W = 32;
  localparam int TAG_W = 8;
  localparam int MICRO_N = 10;
  localparam int MICRO_IDX_W = 4;
  localparam int MAIN_WAYS = 2;
  localparam int MAIN_SETS = 128;
  localparam int SET_W = 7;
  localparam int NUM_SIDES = 2;
  localparam logic [2:0] PROBE_LAST = 3'h5;
  localparam logic [MICRO_IDX_W-1:0] MICRO_LAST = 4'h9;

  // page sizes probed in the main array, as log2 of the page size
  localparam logic [4:0] SHIFT_4K = 5'h0c;
  localparam logic [4:0] SHIFT_64K = 5'h10;
  localparam logic [4:0] SHIFT_1M = 5'h14;
  localparam logic [4:0] SHIFT_2M = 5'h15;
  localparam logic [4:0] SHIFT_16M = 5'h18;
  localparam logic [4:0] SHIFT_1G = 5'h1e;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONTEXT = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAGE2 = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTL_S = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CTL_NS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DOMAIN = 8'h10;
  localparam logic [ADDR_W-1:0] REG_SECCFG = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_FAULT_ADDR = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_TLBOP = 8'h20;

  // control register fields
  localparam int CTL_W = 9;
  localparam int CTL_LFE = 0;
  localparam int CTL_WD0S = 1;
  localparam int CTL_WD1S = 2;
  localparam int CTL_WD0L = 3;
  localparam int CTL_WD1L = 4;
  localparam int CTL_IC0 = 5;
  localparam int CTL_IC1 = 7;
  localparam logic [CTL_W-1:0] CTL_RESET = 9'h000;
  localparam int SEC_ROUTE = 0;
  localparam int STAT_BERR = 0;
  localparam int VA_BASE_SEL = 31;

  localparam logic [1:0] IC_NC = 2'h0;
  localparam logic [1:0] IC_WBWA = 2'h1;
  localparam logic [1:0] IC_WT = 2'h2;
  localparam logic [1:0] IC_WB = 2'h3;

  localparam logic [1:0] DOM_NONE = 2'h0;
  localparam logic [1:0] DOM_MANAGER = 2'h3;
  localparam int AP_EN = 0;
  localparam int AP_USER = 1;
  localparam int AP_RO = 2;

  typedef enum logic [1:0] {
    FLT_NONE, FLT_TRANSLATION, FLT_PERMISSION, FLT_DOMAIN
  } tlbm_fault_e;

  typedef enum logic [2:0] {
    BERR_LOAD, BERR_WRITE_NC, BERR_WRITE_C, BERR_IFETCH_DIRTY, BERR_DVM
  } tlbm_berr_e;

  typedef struct packed {
    logic [VA_W-1:0] va;
    logic [4:0] page_shift;
    logic [PA_W-1:0] pa;
    logic [1:0] mem_type;
    logic [2:0] ap;
    logic [3:0] domain;
    logic global_entry;
    logic [TAG_W-1:0] app_space_tag;
    logic [TAG_W-1:0] virtual_machine_tag;
    logic nonsecure_entry_bit;
    logic hyp;
  } tlbm_entry_s;

  typedef struct packed {
    logic [VA_W-1:0] va;
    logic nonsecure;
    logic hyp;
    logic privileged;
    logic write;
    logic side;
  } tlbm_req_s;

  typedef struct packed {
    logic [PA_W-1:0] pa;
    logic [1:0] mem_type;
    tlbm_fault_e fault;
    logic side;
  } tlbm_resp_s;

  typedef struct packed {
    logic [VA_W-1:0] va;
    logic long_format;
    logic stage2;
    logic to_dcache;
    logic base_sel;
  } tlbm_walk_s;

  typedef struct packed {
    tlbm_berr_e kind;
    logic [VA_W-1:0] addr;
  } tlbm_berr_s;

  typedef struct packed {
    logic sync;
    logic to_monitor;
    logic [VA_W-1:0] addr;
  } tlbm_abort_s;

endpackage

// *** tlbm_walker_model.sv ***
// stand-in for the table walker behind the lookup block
// assumes walk_req_valid is held until the answer pulse
`timescale 1ns/1ns
`default_nettype none
module tlbm_walker_model
  import tlbm_pkg::*;
#(
  parameter int DELAY = 3
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic walk_req_valid,
  input wire tlbm_walk_s walk_req,
  output logic walk_resp_valid,
  output logic walk_resp_fault,
  output tlbm_entry_s walk_resp
);
  int cnt_reg;
  // entry only means something in the answer cycle; scramble it otherwise
  always_ff @(posedge clk) begin
    walk_resp_valid <= 1'b0;
    walk_resp_fault <= 1'b0;
    walk_resp <= tlbm_entry_s'(~walk_resp);
    if (!rst_n) begin
      walk_resp <= '0;
    end
    if (!rst_n || !walk_req_valid) begin
      cnt_reg <= 0;
    end else if (cnt_reg < DELAY) begin
      cnt_reg <= cnt_reg + 1;
    end else if (cnt_reg == DELAY) begin
      cnt_reg <= cnt_reg + 1;
      walk_resp_valid <= 1'b1;
      // high va bits pick failing walks and no-access pages
      walk_resp_fault <= walk_req.va[25];
      walk_resp <= '{va: walk_req.va, page_shift: SHIFT_4K,
        pa: walk_req.va ^ 32'h40000000, mem_type: 2'h1,
        ap: {2'h1, !walk_req.va[24]}, default: '0};
    end
  end
endmodule
`default_nettype wire
